// [host_write_retire_and_cpu_ctrl.sv]
// host write retire, bandwidth period and cpu control logic with apb registers
//
// Notes on behaviour
// - medium retire option on uses medium threshold as flush start level instead of high.
// - read cycle control bit set adds two clocks to memory reads.
// - medium threshold code means code plus one requests, max sixteen.
// - upstream requests accepted every two clocks, or every three with rate bit.
// - graphics hit on queued write with flush bit set flushes the queue.
// - upstream priority bit favours upstream only for high priority requests.
// - early write accept only with extended support and wait hint deasserted.
// - extended support bit loaded from init rom right after bus reset.
// - duration codes 01, 10, 11 give 1050, 1425, 1905 ns reset low.
// - zero-to-one trigger transition drives cpu reset low for chosen time.
// - cpu-to-memory control bit adds one clock to cpu memory accesses.
// - flat redirect sends message interrupts with address bits 11b onward.
// - redirected message data bit 11 passes through or forced one by mask.
// - high and low threshold codes mean code plus one requests.
// - host counter loads preset at reset and on the edge of memory period entry.
// - host counter counts non-memory cpu cycles, reloads on memory cycles.
// - host preset zero means always host period, else that many cycles.
// - memory counter loads preset at reset and on the edge of host period entry.
// - memory counter counts memory cycles, reloads on non-memory cycles.
// - memory preset zero means always memory period, else that many cycles.
// - a period is entered only with its enable set and counter zero.
// - busy with retire on, flush from high threshold down to low.
// - medium option and busy, flush starts at medium threshold instead.
`timescale 1ns/10ps
`default_nettype none
`include "hwr_cfg.svh"
module host_write_retire_and_cpu_ctrl
    import hwr_pkg::*;
(
    input  wire logic        sys_clk,                 // host clock
    input  wire logic        resetn,                  // sync reset, low
    input  wire logic [11:0] paddr,                   // apb address
    input  wire logic        psel,                    // apb select
    input  wire logic        penable,                 // apb enable
    input  wire logic        pwrite,                  // apb direction
    input  wire logic [31:0] pwdata,                  // apb write data
    output logic             pready,                  // apb ready
    output logic             pslverr,                 // apb error
    output logic [31:0]      prdata,                  // apb read data
    input  wire logic        strapRomInitLoad,        // rom load strobe
    input  wire logic        strapRomInitBit,         // rom bit 0 of byte 5
    input  wire logic [3:0]  writeQueueCount,         // queued writes 0..12
    input  wire logic        memReadBusy,             // dram reads in flight
    input  wire logic        graphicsRequesterHit,    // gfx hit on queue entry
    output logic             flushWrites,             // flush queued writes
    input  wire logic        busCycleValid,           // bus cycle issued
    input  wire logic        busCycleFromCpu,         // cycle owner is cpu
    input  wire logic        busCycleToMem,           // cycle targets dram
    output logic             hostTrafficPeriod,       // host period
    output logic             memoryTrafficPeriod,     // memory period
    input  wire logic        upReqValid,              // upstream request
    input  wire logic        upReqHighPri,            // high priority attr
    output logic             upReqReady,              // upstream accept
    output logic             upFavoured,              // upstream wins arbitration
    input  wire logic        downWriteValid,          // downstream write
    input  wire logic        extendedWaitHintRequest, // wait hint from cpu
    output logic             earlyWriteDataAccept,    // early write accept
    input  wire logic        memReadReq,              // dram read request
    output logic             memReadIssue,            // dram read issued
    input  wire logic        cpuMemReq,               // cpu access to dram
    output logic             cpuMemIssue,             // cpu access issued
    output logic             processorResetOutN,      // cpu reset, low
    input  wire logic        msiValid,                // message interrupt cycle
    input  wire logic [1:0]  msiAddrBits,             // address bits 3:2
    input  wire logic [31:0] msiDataIn,               // message data
    output logic             msiRedirect,             // redirect to core
    output logic [31:0]      msiDataOut               // redirected data
);
    // ************************************************************
    // state and next state
    // ************************************************************
    state_t s_r;
    state_t s_nxt;

    logic        apbWr;
    logic        upAccept;
    logic [9:0]  idx;
    logic [4:0]  wqCnt;
    logic [4:0]  startLvl;
    logic [4:0]  lowLvl;

    assign idx      = paddr[11:2];
    assign apbWr    = psel && penable && pwrite && s_r.pready;
    assign upAccept = upReqValid && s_r.upReady;
    assign wqCnt    = {1'b0, writeQueueCount};
    // threshold codes count from one
    assign startLvl = s_r.mctl2[`HWR_B_MEDEN] ? {1'b0, s_r.wpMed[7:4]} + 5'h01
                                              : {1'b0, s_r.wpHl[7:4]} + 5'h01;
    assign lowLvl   = {1'b0, s_r.wpHl[3:0]} + 5'h01;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        // apb slave, zero wait states
        if (psel && !penable && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata  = 32'h0000_0000;
            if (idx == `HWR_IDX_WPMED) begin
                s_nxt.prdata[7:0] = s_r.wpMed;
            end else if (idx == `HWR_IDX_REQSUP) begin
                s_nxt.prdata[7:0] = s_r.reqSup;
            end else if (idx == `HWR_IDX_MISC1) begin
                s_nxt.prdata[7:0] = s_r.misc1;
            end else if (idx == `HWR_IDX_MISC2) begin
                s_nxt.prdata[7:0] = s_r.misc2;
            end else if (idx == `HWR_IDX_WPHL) begin
                s_nxt.prdata[7:0] = s_r.wpHl;
            end else if (idx == `HWR_IDX_BWTIM) begin
                s_nxt.prdata[7:0] = s_r.bwTim;
            end else if (idx == `HWR_IDX_MCTL2) begin
                s_nxt.prdata[7:0] = s_r.mctl2;
            end else if (idx == `HWR_IDX_CTL) begin
                s_nxt.prdata[7:0] = s_r.ctl;
            end else if (idx == `HWR_IDX_STAT) begin
                s_nxt.prdata[7:0] = {s_r.hostCnt, !s_r.cpuResetN, s_r.flush,
                                     s_r.memPer, s_r.hostPer};
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end else if (psel && penable && s_r.pready) begin
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
        end
        // register writes on the completing edge
        if (apbWr) begin
            if (idx == `HWR_IDX_WPMED) begin
                s_nxt.wpMed = pwdata[7:0];
            end else if (idx == `HWR_IDX_REQSUP) begin
                s_nxt.reqSup = pwdata[7:0];
            end else if (idx == `HWR_IDX_MISC1) begin
                s_nxt.misc1 = pwdata[7:0] & `HWR_WM_MISC1;
            end else if (idx == `HWR_IDX_MISC2) begin
                s_nxt.misc2 = pwdata[7:0];
            end else if (idx == `HWR_IDX_WPHL) begin
                s_nxt.wpHl = pwdata[7:0];
            end else if (idx == `HWR_IDX_BWTIM) begin
                s_nxt.bwTim = pwdata[7:0];
            end else if (idx == `HWR_IDX_MCTL2) begin
                s_nxt.mctl2 = (pwdata[7:0] & `HWR_WM_MCTL2) | `HWR_RST_MCTL2;
            end else if (idx == `HWR_IDX_CTL) begin
                s_nxt.ctl = pwdata[7:0];
            end
        end
        // rom load beats a register write in the same cycle
        if (strapRomInitLoad) begin
            s_nxt.reqSup[`HWR_B_EXTREQ] = strapRomInitBit;
        end

        // warm reset pulse, started by a rising trigger bit
        case (s_r.rstSt)
            RST_IDLE: begin
                if (!s_r.misc1[`HWR_B_WTRIG] && s_nxt.misc1[`HWR_B_WTRIG]
                    && (s_nxt.misc1[5:4] != 2'b00)) begin
                    s_nxt.rstSt     = RST_PULSE;
                    s_nxt.cpuResetN = 1'b0;
                    case (s_nxt.misc1[5:4])
                        2'b01:   s_nxt.rstCnt = 9'(`HWR_CYC(`HWR_WRST1_NS));
                        2'b10:   s_nxt.rstCnt = 9'(`HWR_CYC(`HWR_WRST2_NS));
                        default: s_nxt.rstCnt = 9'(`HWR_CYC(`HWR_WRST3_NS));
                    endcase
                end
            end
            RST_PULSE: begin
                if (s_r.rstCnt == 9'h001) begin
                    s_nxt.rstSt     = RST_IDLE;
                    s_nxt.cpuResetN = 1'b1;
                end else begin
                    s_nxt.rstCnt = s_r.rstCnt - 9'h001;
                end
            end
            default: begin
                s_nxt.rstSt     = RST_IDLE;
                s_nxt.cpuResetN = 1'b1;
            end
        endcase

        // bandwidth counters
        if (busCycleValid && busCycleToMem) begin
            s_nxt.hostCnt = s_r.bwTim[7:4];
            if (s_r.memCnt != 4'h0) begin
                s_nxt.memCnt = s_r.memCnt - 4'h1;
            end
        end else if (busCycleValid) begin
            s_nxt.memCnt = s_r.bwTim[3:0];
            if (busCycleFromCpu && (s_r.hostCnt != 4'h0)) begin
                s_nxt.hostCnt = s_r.hostCnt - 4'h1;
            end
        end
        s_nxt.hostPer = s_r.ctl[`HWR_B_HOSTEN] && (s_nxt.hostCnt == 4'h0);
        s_nxt.memPer  = s_r.ctl[`HWR_B_MEMEN] && (s_nxt.memCnt == 4'h0);
        // preload the opposite counter on period entry
        if (s_nxt.hostPer && !s_r.hostPer) begin
            s_nxt.memCnt = s_r.bwTim[3:0];
        end
        if (s_nxt.memPer && !s_r.memPer) begin
            s_nxt.hostCnt = s_r.bwTim[7:4];
        end

        // write retire
        if (!memReadBusy || !s_r.ctl[`HWR_B_RETIREEN]) begin
            s_nxt.flushing = 1'b0;
        end else if (!s_r.flushing && (wqCnt >= startLvl)) begin
            s_nxt.flushing = 1'b1;
        end else if (s_r.flushing && (wqCnt <= lowLvl)) begin
            s_nxt.flushing = 1'b0;
        end
        if (s_r.wpMed[`HWR_B_GFXFLUSH] && graphicsRequesterHit) begin
            s_nxt.gfxFlush = 1'b1;
        end else if (wqCnt == 5'h00) begin
            s_nxt.gfxFlush = 1'b0;
        end
        s_nxt.flush = (wqCnt != 5'h00)
                      && (!memReadBusy || s_nxt.flushing || s_nxt.gfxFlush
                          || (wqCnt >= `HWR_WQ_FULL));

        // upstream request rate and priority
        if (upAccept) begin
            s_nxt.rateCnt = s_r.wpMed[`HWR_B_UPRATE3] ? 2'd2 : 2'd1;
        end else if (s_r.rateCnt != 2'd0) begin
            s_nxt.rateCnt = s_r.rateCnt - 2'd1;
        end
        s_nxt.upReady    = (s_nxt.rateCnt == 2'd0);
        s_nxt.upFavoured = s_r.wpMed[`HWR_B_UPPRIO] && upReqHighPri && upReqValid;

        // early write accept
        s_nxt.earlyAccept = s_r.reqSup[`HWR_B_EXTREQ] && s_r.ctl[`HWR_B_EARLYEN]
                            && downWriteValid && !extendedWaitHintRequest;

        // read and cpu access delay lines
        s_nxt.readPipe  = {s_r.readPipe[0], memReadReq};
        s_nxt.readIssue = s_r.mctl2[`HWR_B_RDSLOW] ? s_r.readPipe[1] : memReadReq;
        s_nxt.cpuPipe   = cpuMemReq;
        s_nxt.cpuIssue  = s_r.misc1[`HWR_B_CPUDLY] ? s_r.cpuPipe : cpuMemReq;

        // message interrupt redirection
        s_nxt.msiRedirect = msiValid && s_r.misc1[`HWR_B_FLATMSI]
                            && (msiAddrBits == 2'b11);
        s_nxt.msiData = msiDataIn;
        if (s_r.misc2[`HWR_B_D11MASK]) begin
            s_nxt.msiData[11] = 1'b1;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_r           <= '0;
            s_r.wpMed     <= `HWR_RST_WPMED;
            s_r.reqSup    <= `HWR_RST_REQSUP;
            s_r.misc1     <= `HWR_RST_MISC1;
            s_r.misc2     <= `HWR_RST_MISC2;
            s_r.wpHl      <= `HWR_RST_WPHL;
            s_r.bwTim     <= `HWR_RST_BWTIM;
            s_r.mctl2     <= `HWR_RST_MCTL2;
            s_r.ctl       <= `HWR_RST_CTL;
            s_r.upReady   <= 1'b1;
            s_r.rstSt     <= RST_IDLE;
            s_r.cpuResetN <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign pready               = s_r.pready;
    assign pslverr              = s_r.pslverr;
    assign prdata               = s_r.prdata;
    assign flushWrites          = s_r.flush;
    assign hostTrafficPeriod    = s_r.hostPer;
    assign memoryTrafficPeriod  = s_r.memPer;
    assign upReqReady           = s_r.upReady;
    assign upFavoured           = s_r.upFavoured;
    assign earlyWriteDataAccept = s_r.earlyAccept;
    assign memReadIssue         = s_r.readIssue;
    assign cpuMemIssue          = s_r.cpuIssue;
    assign processorResetOutN   = s_r.cpuResetN;
    assign msiRedirect          = s_r.msiRedirect;
    assign msiDataOut           = s_r.msiData;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // helper: length of the last reset low pulse
    logic [8:0] lowLen;
    logic [1:0] lowCode;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lowLen  <= 9'h000;
            lowCode <= 2'b00;
        end else if (!s_r.cpuResetN) begin
            lowLen <= lowLen + 9'h001;
        end else begin
            lowLen  <= 9'h000;
            lowCode <= s_r.misc1[5:4];
        end
    end

    property p_rst_len;
        $rose(s_r.cpuResetN) |-> (lowCode == 2'b01 && lowLen == 9'd210)
            || (lowCode == 2'b10 && lowLen == 9'd285) || (lowCode == 2'b11 && lowLen == 9'd381);
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
    property p_rst_start;
        !s_r.misc1[3] ##1 s_r.misc1[3] && s_r.misc1[5:4] != 2'b00 |-> !s_r.cpuResetN;
    endproperty
    a_rst_start: assert property (p_rst_start) else $error("no reset pulse on trigger");
    property p_rate;
        upAccept && s_r.wpMed[2] |=> !s_r.upReady [*2] ##1 s_r.upReady;
    endproperty
    a_rate: assert property (p_rate) else $error("upstream rate wrong");
    property p_read_slow;
        (memReadReq && s_r.mctl2[1]) ##1 s_r.mctl2[1] ##1 s_r.mctl2[1] |=> s_r.readIssue;
    endproperty
    a_read_slow: assert property (p_read_slow) else $error("slow read not issued");
    property p_cpu_dly;
        (cpuMemReq && s_r.misc1[2]) ##1 s_r.misc1[2] |-> !s_r.cpuIssue ##1 s_r.cpuIssue;
    endproperty
    a_cpu_dly: assert property (p_cpu_dly) else $error("cpu access delay wrong");
    property p_early;
        s_r.earlyAccept |-> $past(s_r.reqSup[0] && !extendedWaitHintRequest);
    endproperty
    a_early: assert property (p_early) else $error("early accept not allowed");
    property p_prio;
        s_r.upFavoured |-> $past(s_r.wpMed[0] && upReqHighPri);
    endproperty
    a_prio: assert property (p_prio) else $error("upstream favoured wrongly");
    property p_msi;
        msiValid && msiAddrBits == 2'b11 && s_r.misc1[0] && s_r.misc2[4]
            |=> s_r.msiRedirect && s_r.msiData[11];
    endproperty
    a_msi: assert property (p_msi) else $error("message redirect wrong");
    property p_medium;
        memReadBusy && s_r.ctl[0] && s_r.mctl2[2] && !s_r.flushing
            && wqCnt >= {1'b0, s_r.wpMed[7:4]} + 5'h01 |=> s_r.flushing;
    endproperty
    a_medium: assert property (p_medium) else $error("medium flush missed");
    property p_period;
        s_r.hostPer |-> $past(s_r.ctl[1]);
    endproperty
    a_period: assert property (p_period) else $error("host period without enable");

    c_rst: cover property ($rose(s_r.cpuResetN));
    c_flush: cover property ($rose(s_r.flushing));
    c_periods: cover property (s_r.hostPer ##[1:20] s_r.memPer);
endmodule
`default_nettype wire

// [hwr_cfg.svh]
// register indexes, field positions, reset values and timing counts for the host control block
`ifndef HWR_CFG_SVH
`define HWR_CFG_SVH
// register indexes (byte address is four times the index)
`define HWR_IDX_WPMED   10'h056
`define HWR_IDX_REQSUP  10'h057
`define HWR_IDX_MISC1   10'h059
`define HWR_IDX_MISC2   10'h05C
`define HWR_IDX_WPHL    10'h05D
`define HWR_IDX_BWTIM   10'h05E
`define HWR_IDX_MCTL2   10'h055
`define HWR_IDX_CTL     10'h070
`define HWR_IDX_STAT    10'h071
// reset values and writable masks
`define HWR_RST_WPMED   8'h00
`define HWR_RST_REQSUP  8'h07
`define HWR_RST_MISC1   8'h08
`define HWR_RST_MISC2   8'h00
`define HWR_RST_WPHL    8'h00
`define HWR_RST_BWTIM   8'h00
`define HWR_RST_MCTL2   8'h20
`define HWR_RST_CTL     8'h00
`define HWR_WM_MISC1    8'hFD
`define HWR_WM_MCTL2    8'h1E
// field positions
`define HWR_B_MEDEN     2
`define HWR_B_RDSLOW    1
`define HWR_B_UPRATE3   2
`define HWR_B_GFXFLUSH  1
`define HWR_B_UPPRIO    0
`define HWR_B_EXTREQ    0
`define HWR_B_WTRIG     3
`define HWR_B_CPUDLY    2
`define HWR_B_FLATMSI   0
`define HWR_B_D11MASK   4
`define HWR_B_RETIREEN  0
`define HWR_B_HOSTEN    1
`define HWR_B_MEMEN     2
`define HWR_B_EARLYEN   3
// write queue depth in entries
`define HWR_WQ_FULL     5'h0C
// warm reset low times, clock period and derived cycle counts (rounded up)
`define HWR_CLK_PS      5000
`define HWR_WRST1_NS    1050
`define HWR_WRST2_NS    1425
`define HWR_WRST3_NS    1905
`define HWR_CYC(ns)     ((((ns) * 1000) + `HWR_CLK_PS - 1) / `HWR_CLK_PS)
`endif

// [hwr_pkg.sv]
// types for the host control block
`include "hwr_cfg.svh"
package hwr_pkg;
    // warm reset sequencer states
    typedef enum logic [1:0] {
        RST_IDLE  = 2'b01,
        RST_PULSE = 2'b10
    } rst_state_t;

    // complete state of the block
    typedef struct packed {
        logic [7:0]  wpMed;
        logic [7:0]  reqSup;
        logic [7:0]  misc1;
        logic [7:0]  misc2;
        logic [7:0]  wpHl;
        logic [7:0]  bwTim;
        logic [7:0]  mctl2;
        logic [7:0]  ctl;
        logic [3:0]  hostCnt;
        logic [3:0]  memCnt;
        logic        hostPer;
        logic        memPer;
        logic        flushing;
        logic        gfxFlush;
        logic        flush;
        logic [1:0]  rateCnt;
        logic        upReady;
        logic        upFavoured;
        logic        earlyAccept;
        logic [1:0]  readPipe;
        logic        cpuPipe;
        logic        readIssue;
        logic        cpuIssue;
        logic [8:0]  rstCnt;
        rst_state_t  rstSt;
        logic        cpuResetN;
        logic        msiRedirect;
        logic [31:0] msiData;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;
endpackage

// [fsb_partner.sv]
// bus cycle source standing in for the processor bus and its masters
`timescale 1ns/10ps
`default_nettype none
module fsb_partner (
    input  wire logic sys_clk,                // host clock
    input  wire logic go,                     // issue one bus cycle
    input  wire logic toMem,                  // that cycle targets dram
    output logic      busCycleValid = 1'b0,   // one pulse per cycle
    output logic      busCycleFromCpu = 1'b0, // owner is cpu
    output logic      busCycleToMem = 1'b0    // target is dram
);
    // attributes toggle while idle so that nothing may lean on them
    always_ff @(posedge sys_clk) begin
        busCycleValid <= go;
        busCycleFromCpu <= go ? 1'b1 : ~busCycleFromCpu;
        busCycleToMem <= go ? toMem : ~busCycleToMem;
    end
endmodule
`default_nettype wire

// [host_write_retire_and_cpu_ctrl_tb_top.sv]
// self-checking bench for the host control block
`timescale 1ns/10ps
`default_nettype none
`include "hwr_cfg.svh"
module host_write_retire_and_cpu_ctrl_tb_top;
    import hwr_pkg::*;
    // ****************
    // stimulus and observed signals
    // ****************
    logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, msiDataIn = 32'h0, prdata, msiDataOut, rd;
    logic        strapRomInitLoad = 1'b0, strapRomInitBit = 1'b0, memReadBusy = 1'b0;
    logic [3:0]  writeQueueCount = 4'h0;
    logic        graphicsRequesterHit = 1'b0, upReqValid = 1'b0, upReqHighPri = 1'b0;
    logic        downWriteValid = 1'b0, extendedWaitHintRequest = 1'b0, memReadReq = 1'b0;
    logic        cpuMemReq = 1'b0, msiValid = 1'b0, go = 1'b0, toMem = 1'b0, er;
    logic [1:0]  msiAddrBits = 2'h0;
    logic        pready, pslverr, flushWrites, hostTrafficPeriod, memoryTrafficPeriod;
    logic        upReqReady, upFavoured, earlyWriteDataAccept, memReadIssue, cpuMemIssue;
    logic        processorResetOutN, msiRedirect, busCycleValid, busCycleFromCpu, busCycleToMem;
    int          bad_count = 0;
    int          checked = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    host_write_retire_and_cpu_ctrl i_dut (.*);
    fsb_partner i_far (.*);

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // apb transfer, returns at the edge where pready is sampled
    task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            close_out();
        end
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic regs();
        logic [9:0] ix [6] = '{`HWR_IDX_WPMED, `HWR_IDX_REQSUP, `HWR_IDX_MISC1,
                               `HWR_IDX_MISC2, `HWR_IDX_BWTIM, `HWR_IDX_MCTL2};
        logic [7:0] rv [6] = '{8'h00, 8'h07, 8'h08, 8'h00, 8'h00, 8'h20};
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, ix[k], 8'h00);
            chk("reset value", rd, {24'h000000, rv[k]});
        end
        apb(1'b0, 10'h3FF, 8'h00);
        chk("unmapped error", er, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, `HWR_IDX_WPMED, 8'hB3);
        apb(1'b0, `HWR_IDX_WPMED, 8'h00);
        chk("medium field", rd, 32'hB3);
        $display("test registers done");
    endtask

    task automatic lat(input logic [7:0] v55, input logic [7:0] v59, input int ea, input int eb);
        int a, b;
        a = 0;
        b = 0;
        apb(1'b1, `HWR_IDX_MCTL2, v55);
        apb(1'b1, `HWR_IDX_MISC1, v59);
        memReadReq <= 1'b1;
        cpuMemReq <= 1'b1;
        @(posedge sys_clk);
        memReadReq <= 1'b0;
        cpuMemReq <= 1'b0;
        for (int i = 1; i < 6; i++) begin
            @(posedge sys_clk);
            if (memReadIssue === 1'b1 && a == 0) a = i;
            if (cpuMemIssue === 1'b1 && b == 0) b = i;
        end
        chk("read issue delay", a, ea);
        chk("cpu access delay", b, eb);
        $display("test latency done");
    endtask

    task automatic warm();
        int n;
        int want [3] = '{210, 285, 381};
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, `HWR_IDX_MISC1, 8'(c * 16));
            apb(1'b1, `HWR_IDX_MISC1, 8'(c * 16) | 8'h08);
            n = 0;
            @(posedge sys_clk);
            while (processorResetOutN === 1'b0 && n < 500) begin
                n++;
                @(posedge sys_clk);
            end
            chk("reset low cycles", n, want[c-1]);
        end
        apb(1'b1, `HWR_IDX_MISC1, 8'h38);
        @(posedge sys_clk);
        chk("no pulse on rewrite", processorResetOutN, 32'h1);
        $display("test warm reset done");
    endtask

    task automatic msi(input logic [1:0] ab, input logic ex, input logic [31:0] d);
        msiValid <= 1'b1;
        msiAddrBits <= ab;
        @(posedge sys_clk);
        msiValid <= 1'b0;
        @(posedge sys_clk);
        chk("redirect", msiRedirect, ex);
        if (ex) chk("redirect data", msiDataOut, d);
    endtask

    task automatic cyc(input logic m);
        go <= 1'b1;
        toMem <= m;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic periods();
        apb(1'b1, `HWR_IDX_BWTIM, 8'h20);
        cyc(1'b1);
        apb(1'b1, `HWR_IDX_CTL, 8'h02);
        cyc(1'b0);
        chk("host period early", hostTrafficPeriod, 32'h0);
        cyc(1'b0);
        chk("host period", hostTrafficPeriod, 32'h1);
        chk("memory period off", memoryTrafficPeriod, 32'h0);
        $display("test periods done");
    endtask

    task automatic sideband();
        int n;
        apb(1'b1, `HWR_IDX_CTL, 8'h09);
        strapRomInitLoad <= 1'b1;
        @(posedge sys_clk);
        strapRomInitLoad <= 1'b0;
        apb(1'b0, `HWR_IDX_REQSUP, 8'h00);
        chk("rom bit", rd, 32'h06);
        downWriteValid <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            if (k == 1) apb(1'b1, `HWR_IDX_REQSUP, 8'h07);
            extendedWaitHintRequest <= (k == 2);
            repeat (2) @(posedge sys_clk);
            chk("early accept", earlyWriteDataAccept, k == 1);
        end
        for (int r = 2; r < 4; r++) begin
            n = 0;
            upReqValid <= 1'b1;
            upReqHighPri <= (r == 2);
            repeat (6) begin
                @(posedge sys_clk);
                if (upReqReady === 1'b1) n++;
            end
            upReqValid <= 1'b0;
            chk("up accepts", n, 6 / r);
            chk("up favoured", upFavoured, r == 2);
            apb(1'b1, `HWR_IDX_WPMED, 8'h47);
        end
        $display("test sideband done");
    endtask

    task automatic retire();
        logic [3:0] q [5] = '{4'h5, 4'h9, 4'h3, 4'h5, 4'h2};
        logic       f [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        apb(1'b1, `HWR_IDX_WPHL, 8'h82);
        memReadBusy <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            if (k == 3) apb(1'b1, `HWR_IDX_MCTL2, 8'h06);
            graphicsRequesterHit <= (k == 4);
            writeQueueCount <= q[k];
            repeat (2) @(posedge sys_clk);
            chk("flush", flushWrites, f[k]);
        end
        apb(1'b1, `HWR_IDX_BWTIM, 8'h02);
        apb(1'b1, `HWR_IDX_CTL, 8'h04);
        cyc(1'b0);
        cyc(1'b1);
        chk("mem period early", memoryTrafficPeriod, 32'h0);
        cyc(1'b1);
        chk("mem period", memoryTrafficPeriod, 32'h1);
        $display("test retire done");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        regs();
        lat(8'h00, 8'h08, 1, 1);
        lat(8'h02, 8'h0C, 3, 2);
        warm();
        apb(1'b1, `HWR_IDX_MISC1, 8'h09);
        apb(1'b1, `HWR_IDX_MISC2, 8'h10);
        msi(2'b11, 1'b1, 32'h00000800);
        msi(2'b01, 1'b0, 32'h0);
        apb(1'b1, `HWR_IDX_MISC2, 8'h00);
        msi(2'b11, 1'b1, 32'h0);
        $display("test message interrupt done");
        periods();
        sideband();
        retire();
        close_out();
    end
endmodule
`default_nettype wire
